// ==== verilog/csp_pkg.sv ====
// Purpose: Shared constants and types for the two-wire control slave port.
// Assumes: Registers are 8 bits wide and each page holds 128 of them.
// Notes: The engine faces the link clock, the register bank faces mclk.
package csp_pkg;

  // Bus address of this slave and the general-call address.
  localparam logic [6:0] CSP_DEV_ADDR = 7'h18;
  localparam logic [6:0] CSP_GC_ADDR = 7'h00;

  // Register 0 of every page selects the page; page 0 register 34 bit 5 enables general call.
  localparam logic [6:0] CSP_PAGE_REG = 7'h00;
  localparam logic [6:0] CSP_GC_REG = 7'h22;
  localparam int CSP_GC_BIT = 5;
  localparam logic [7:0] CSP_PAGE_RESET = 8'h00;
  localparam logic [7:0] CSP_GC_PAGE = 8'h00;

  // Bits per byte on the wire and the bit-counter value at the byte's end.
  localparam logic [3:0] CSP_BYTE_BITS = 4'h8;
  localparam logic [3:0] CSP_LAST_BIT = 4'h7;
  localparam logic [3:0] CSP_BIT_ZERO = 4'h0;
  localparam logic [7:0] CSP_PTR_STEP = 8'h01;

  // Synchroniser depths: three stages for pins, two for internal levels and toggles.
  localparam int CSP_PIN_STAGES = 3;
  localparam int CSP_LVL_STAGES = 2;

  // Byte engine states, Gray coded along the usual write and read path.
  typedef enum logic [2:0] {
    CSP_IDLE     = 3'b000,
    CSP_ADDR     = 3'b001,
    CSP_ADDR_ACK = 3'b011,
    CSP_WR_BYTE  = 3'b010,
    CSP_WR_ACK   = 3'b110,
    CSP_RD_BYTE  = 3'b111,
    CSP_RD_ACK   = 3'b101,
    CSP_IGNORE   = 3'b100
  } csp_state_t;

  // Register request passed from the link domain to the mclk domain.
  typedef struct packed {
    logic wr;
    logic [6:0] idx;
    logic [7:0] data;
  } csp_req_t;

  // Register write event shown to the rest of the device.
  typedef struct packed {
    logic [7:0] page;
    logic [6:0] idx;
    logic [7:0] data;
  } csp_wr_t;

endpackage : csp_pkg

// ==== verilog/csp_sync.sv ====
// Purpose: Chain of flip-flops that brings a level into another clock domain.
// Assumes: The input is a level or a toggle, never a one-cycle pulse.
// Notes: Stage 0 feeds only stage 1; callers read the later stages.
`timescale 1ns/1ps
`default_nettype none
module csp_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  input wire logic rst_val,
  output logic [STAGES-1:0] q
);

  // Reset loads a constant chosen per instance through a tie-off of fixed value.
  logic [STAGES-1:0] chain_reg;

  // Plain shift chain; the reset value is a constant tie at the instance.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= {chain_reg[STAGES-2:0], d ^ rst_val};
    end
  end

  // The idle level is restored after the chain so reset shows the line's resting value.
  assign q = chain_reg ^ {STAGES{rst_val}};

endmodule : csp_sync
`default_nettype wire

// ==== verilog/csp_regbank.sv ====
// Purpose: Byte-wide register storage for all pages reached through the port.
// Assumes: One write or one read per clock, driven from the mclk domain.
// Notes: Read data come out of a register one clock after the address.
`timescale 1ns/1ps
`default_nettype none
module csp_regbank #(
  parameter int AW = 11,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  // Storage has no reset; software must write a register before relying on it.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // Registered read port.
  always_ff @(posedge clk) begin
    rdata <= mem[addr];
  end

endmodule : csp_regbank
`default_nettype wire

// ==== verilog/csp_top.sv ====
// Purpose: Two-wire slave port giving an external master access to paged 8-bit control registers.
// Assumes: link_clk runs free and fast against the bus clock; SCL and SDA come straight from pins.
// Notes: The byte engine runs on link_clk, the register bank and page on mclk.
// How it works
// - Acknowledge only address 0011000 or an enabled general call; ignore the rest.
// - Pure slave: never makes START or STOP, never drives the clock line.
// - Data line is only pulled low or released, never driven high.
// - Every byte is eight bits, MSB first, then one acknowledge bit.
// - Data changes only while clock is low; received bits taken at clock high.
// - START is data falling with clock high; STOP is data rising with clock high.
// - After each byte addressed to us, data line is held low for bit nine.
// - Not-acknowledge is data left high; foreign addresses are never acknowledged.
// - We drive data bits on reads; on writes we drive only the acknowledge.
// - START during a transfer restarts address decoding, no STOP needed.
// - STOP ends the transfer and returns the engine to idle.
// - General call acknowledged only when page 0 register 34 bit 5 is set.
// - Further written bytes go to successive register numbers.
// - Master acknowledge on a read makes us send the next register.
// - Every register is 8 bits, bit 7 most significant.
// - Writing register 0 of any page selects the current page.
// - Current page is 0 after reset.
`timescale 1ns/1ps
`default_nettype none
module csp_top
  import csp_pkg::*;
#(
  parameter int PAGE_AW = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [7:0] cur_page,
  output logic gc_enable,
  output logic reg_wr_valid,
  output var csp_wr_t reg_wr
);

  // Link-domain reset: asserts at once, releases two link edges after sys_rst drops.
  logic [1:0] rst_link_chain_reg;
  logic rst_link;

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_link_chain_reg <= 2'b11;
    end else begin
      rst_link_chain_reg <= {rst_link_chain_reg[0], 1'b0};
    end
  end
  assign rst_link = rst_link_chain_reg[1];

  // Pin synchronisers; the bus lines rest high, so reset shows them high.
  logic [CSP_PIN_STAGES-1:0] scl_sv;
  logic [CSP_PIN_STAGES-1:0] sda_sv;

  csp_sync #(.STAGES(CSP_PIN_STAGES)) u_scl_sync (
    .clk(link_clk), .rst(rst_link), .d(scl_in), .rst_val(1'b1), .q(scl_sv)
  );
  csp_sync #(.STAGES(CSP_PIN_STAGES)) u_sda_sync (
    .clk(link_clk), .rst(rst_link), .d(sda_in), .rst_val(1'b1), .q(sda_sv)
  );

  // A line level is accepted only when stages two and three agree, which rejects single-cycle glitches.
  logic scl_f_reg;
  logic sda_f_reg;
  logic scl_d_reg;
  logic sda_d_reg;

  always_ff @(posedge link_clk or posedge rst_link) begin
    if (rst_link) begin
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      if (scl_sv[1] == scl_sv[2]) begin
        scl_f_reg <= scl_sv[2];
      end
      if (sda_sv[1] == sda_sv[2]) begin
        sda_f_reg <= sda_sv[2];
      end
      scl_d_reg <= scl_f_reg;
      sda_d_reg <= sda_f_reg;
    end
  end

  // Bus events from the filtered lines.
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;

  assign scl_rise = scl_f_reg && !scl_d_reg;
  assign scl_fall = !scl_f_reg && scl_d_reg;
  assign start_evt = scl_f_reg && scl_d_reg && sda_d_reg && !sda_f_reg;
  assign stop_evt = scl_f_reg && scl_d_reg && !sda_d_reg && sda_f_reg;

  // Byte engine state.
  csp_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic idx_pending_reg;
  logic read_dir_reg;
  logic master_ack_reg;
  logic hold_low_reg;

  // Register request toward mclk and the answer coming back.
  csp_req_t req_pkt_reg;
  logic req_tog_reg;
  logic rsp_tog_reg;
  logic [7:0] rsp_data_reg;
  logic [7:0] rd_data_reg;
  logic rsp_seen_reg;
  logic [CSP_LVL_STAGES-1:0] rsp_sv;
  logic [CSP_LVL_STAGES-1:0] gc_sv;
  logic addr_hit;
  logic gc_hit;

  csp_sync #(.STAGES(CSP_LVL_STAGES)) u_rsp_sync (
    .clk(link_clk), .rst(rst_link), .d(rsp_tog_reg), .rst_val(1'b0), .q(rsp_sv)
  );
  csp_sync #(.STAGES(CSP_LVL_STAGES)) u_gc_sync (
    .clk(link_clk), .rst(rst_link), .d(gc_enable), .rst_val(1'b0), .q(gc_sv)
  );

  // General call is only a write, and only when enabled.
  assign gc_hit = (shift_reg[7:1] == CSP_GC_ADDR) && !shift_reg[0] && gc_sv[1];
  assign addr_hit = (shift_reg[7:1] == CSP_DEV_ADDR) || gc_hit;

  // Next byte pointer; wraps at 8 bits.
  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    ptr_inc = p + CSP_PTR_STEP;
  endfunction : ptr_inc

  // Main engine; START and STOP outrank bit traffic in every state.
  always_ff @(posedge link_clk or posedge rst_link) begin
    if (rst_link) begin
      state_reg <= CSP_IDLE;
      bit_cnt_reg <= CSP_BIT_ZERO;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      idx_pending_reg <= 1'b0;
      read_dir_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      hold_low_reg <= 1'b0;
    end else if (start_evt) begin
      state_reg <= CSP_ADDR;
      bit_cnt_reg <= CSP_BIT_ZERO;
      hold_low_reg <= 1'b0;
    end else if (stop_evt) begin
      state_reg <= CSP_IDLE;
      hold_low_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        CSP_IDLE, CSP_IGNORE: begin
          hold_low_reg <= 1'b0;
        end
        CSP_ADDR, CSP_WR_BYTE: begin
          // Received bits are taken on the rising clock, MSB first.
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_f_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == CSP_BYTE_BITS) begin
            if (state_reg == CSP_WR_BYTE) begin
              hold_low_reg <= 1'b1;
              state_reg <= CSP_WR_ACK;
              if (idx_pending_reg) begin
                ptr_reg <= shift_reg;
                idx_pending_reg <= 1'b0;
              end else begin
                ptr_reg <= ptr_inc(ptr_reg);
              end
            end else if (addr_hit) begin
              hold_low_reg <= 1'b1;
              read_dir_reg <= shift_reg[0];
              idx_pending_reg <= !shift_reg[0];
              state_reg <= CSP_ADDR_ACK;
            end else begin
              state_reg <= CSP_IGNORE;
            end
          end
        end
        CSP_ADDR_ACK, CSP_WR_ACK: begin
          // The master clocks the acknowledge; release it on the following fall.
          if (scl_fall) begin
            bit_cnt_reg <= CSP_BIT_ZERO;
            if (state_reg == CSP_ADDR_ACK && read_dir_reg) begin
              shift_reg <= {rd_data_reg[6:0], 1'b0};
              hold_low_reg <= !rd_data_reg[7];
              ptr_reg <= ptr_inc(ptr_reg);
              state_reg <= CSP_RD_BYTE;
            end else begin
              hold_low_reg <= 1'b0;
              state_reg <= CSP_WR_BYTE;
            end
          end
        end
        CSP_RD_BYTE: begin
          // Our bits change only on the falling clock.
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == CSP_LAST_BIT) begin
              hold_low_reg <= 1'b0;
              state_reg <= CSP_RD_ACK;
            end else begin
              hold_low_reg <= !shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
            end
          end
        end
        CSP_RD_ACK: begin
          if (scl_rise) begin
            master_ack_reg <= !sda_f_reg;
          end else if (scl_fall) begin
            bit_cnt_reg <= CSP_BIT_ZERO;
            if (master_ack_reg) begin
              shift_reg <= {rd_data_reg[6:0], 1'b0};
              hold_low_reg <= !rd_data_reg[7];
              ptr_reg <= ptr_inc(ptr_reg);
              state_reg <= CSP_RD_BYTE;
            end else begin
              state_reg <= CSP_IGNORE;
            end
          end
        end
      endcase
    end
  end

  // Register requests: reads are fetched during the acknowledge bit so data wait for the next fall.
  always_ff @(posedge link_clk or posedge rst_link) begin
    if (rst_link) begin
      req_pkt_reg <= '0;
      req_tog_reg <= 1'b0;
    end else if (!start_evt && !stop_evt && scl_fall) begin
      if (state_reg == CSP_ADDR && bit_cnt_reg == CSP_BYTE_BITS && addr_hit && shift_reg[0]) begin
        req_pkt_reg <= '{wr: 1'b0, idx: ptr_reg[6:0], data: 8'h00};
        req_tog_reg <= !req_tog_reg;
      end else if (state_reg == CSP_WR_BYTE && bit_cnt_reg == CSP_BYTE_BITS && !idx_pending_reg) begin
        req_pkt_reg <= '{wr: 1'b1, idx: ptr_reg[6:0], data: shift_reg};
        req_tog_reg <= !req_tog_reg;
      end else if (state_reg == CSP_RD_BYTE && bit_cnt_reg == CSP_LAST_BIT) begin
        req_pkt_reg <= '{wr: 1'b0, idx: ptr_reg[6:0], data: 8'h00};
        req_tog_reg <= !req_tog_reg;
      end
    end
  end

  // Read answers arrive as a toggle; the data register is stable by the time it is seen.
  always_ff @(posedge link_clk or posedge rst_link) begin
    if (rst_link) begin
      rsp_seen_reg <= 1'b0;
      rd_data_reg <= 8'h00;
    end else begin
      rsp_seen_reg <= rsp_sv[1];
      if (rsp_sv[1] != rsp_seen_reg) begin
        rd_data_reg <= rsp_data_reg;
      end
    end
  end

  // Open-drain data line: we only ever pull low, and there is no clock output at all.
  assign sda_out = 1'b0;
  assign sda_oe_n = !hold_low_reg;

  // Request toggle into the mclk domain.
  logic [CSP_LVL_STAGES-1:0] req_sv;
  logic req_seen_reg;
  logic req_evt;
  logic rd_pend_reg;
  logic [7:0] page_reg;
  logic gc_en_reg;
  logic [7:0] bank_rdata;
  logic bank_we;
  logic [PAGE_AW+6:0] bank_addr;

  csp_sync #(.STAGES(CSP_LVL_STAGES)) u_req_sync (
    .clk(mclk), .rst(sys_rst), .d(req_tog_reg), .rst_val(1'b0), .q(req_sv)
  );

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      req_seen_reg <= 1'b0;
    end else begin
      req_seen_reg <= req_sv[1];
    end
  end
  assign req_evt = req_sv[1] != req_seen_reg;

  // Page select and general-call enable live beside the bank so reads of them come back right.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      page_reg <= CSP_PAGE_RESET;
      gc_en_reg <= 1'b0;
    end else if (req_evt && req_pkt_reg.wr) begin
      if (req_pkt_reg.idx == CSP_PAGE_REG) begin
        page_reg <= req_pkt_reg.data;
      end
      if (page_reg == CSP_GC_PAGE && req_pkt_reg.idx == CSP_GC_REG) begin
        gc_en_reg <= req_pkt_reg.data[CSP_GC_BIT];
      end
    end
  end

  // Only the low page bits index storage; higher pages alias onto those present.
  assign bank_we = req_evt && req_pkt_reg.wr && req_pkt_reg.idx != CSP_PAGE_REG;
  assign bank_addr = {page_reg[PAGE_AW-1:0], req_pkt_reg.idx};

  csp_regbank #(.AW(PAGE_AW + 7), .DW(8)) u_bank (
    .clk(mclk), .we(bank_we), .addr(bank_addr), .wdata(req_pkt_reg.data), .rdata(bank_rdata)
  );

  // Read answer one clock after the bank read, then the toggle back to the link.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
      rsp_tog_reg <= 1'b0;
    end else begin
      rd_pend_reg <= req_evt && !req_pkt_reg.wr;
      if (rd_pend_reg) begin
        rsp_data_reg <= (req_pkt_reg.idx == CSP_PAGE_REG) ? page_reg : bank_rdata;
        rsp_tog_reg <= !rsp_tog_reg;
      end
    end
  end

  // Write notification for the rest of the device.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_wr_valid <= 1'b0;
      reg_wr <= '0;
    end else begin
      reg_wr_valid <= req_evt && req_pkt_reg.wr;
      reg_wr <= '{page: page_reg, idx: req_pkt_reg.idx, data: req_pkt_reg.data};
    end
  end

  assign cur_page = page_reg;
  assign gc_enable = gc_en_reg;

  // Checks on the link side, and one page-select check on mclk.
  start_restart_a: assert property (@(posedge link_clk) disable iff (rst_link)
    start_evt |=> state_reg == CSP_ADDR && bit_cnt_reg == CSP_BIT_ZERO && sda_oe_n)
    else $error("START did not restart address decoding");
  stop_idle_a: assert property (@(posedge link_clk) disable iff (rst_link)
    stop_evt && !start_evt |=> state_reg == CSP_IDLE && sda_oe_n)
    else $error("STOP did not return to idle");
  own_addr_ack_a: assert property (@(posedge link_clk) disable iff (rst_link)
    state_reg == CSP_ADDR && !start_evt && !stop_evt && scl_fall && bit_cnt_reg == CSP_BYTE_BITS
    && shift_reg[7:1] == CSP_DEV_ADDR |=> !sda_oe_n && state_reg == CSP_ADDR_ACK)
    else $error("Own address not acknowledged");
  foreign_nack_a: assert property (@(posedge link_clk) disable iff (rst_link)
    state_reg == CSP_ADDR && !start_evt && !stop_evt && scl_fall && bit_cnt_reg == CSP_BYTE_BITS
    && shift_reg[7:1] != CSP_DEV_ADDR && shift_reg[7:1] != CSP_GC_ADDR |=> state_reg == CSP_IGNORE && sda_oe_n)
    else $error("Foreign address acknowledged");
  gen_call_gate_a: assert property (@(posedge link_clk) disable iff (rst_link)
    state_reg == CSP_ADDR && !start_evt && !stop_evt && scl_fall && bit_cnt_reg == CSP_BYTE_BITS
    && shift_reg[7:1] == CSP_GC_ADDR && !gc_sv[1] |=> sda_oe_n[*2])
    else $error("General call acknowledged while disabled");
  write_no_drive_a: assert property (@(posedge link_clk) disable iff (rst_link)
    state_reg == CSP_WR_BYTE |-> sda_oe_n)
    else $error("Data line driven during a written byte");
  drive_scl_low_a: assert property (@(posedge link_clk) disable iff (rst_link)
    $changed(sda_oe_n) && !$past(start_evt) && !$past(stop_evt) |-> !scl_f_reg)
    else $error("Data line changed while clock high");
  read_eight_a: assert property (@(posedge link_clk) disable iff (rst_link)
    state_reg == CSP_RD_BYTE && !start_evt && !stop_evt && scl_fall && bit_cnt_reg == CSP_LAST_BIT
    |=> state_reg == CSP_RD_ACK && sda_oe_n)
    else $error("Read byte not released after eight bits");
  auto_inc_a: assert property (@(posedge link_clk) disable iff (rst_link)
    state_reg == CSP_WR_BYTE && !start_evt && !stop_evt && scl_fall && bit_cnt_reg == CSP_BYTE_BITS
    && !idx_pending_reg |=> ptr_reg == ptr_inc($past(ptr_reg)) && req_pkt_reg.wr)
    else $error("Write pointer did not advance");
  page_select_a: assert property (@(posedge mclk) disable iff (sys_rst)
    req_evt && req_pkt_reg.wr && req_pkt_reg.idx == CSP_PAGE_REG |=> cur_page == $past(req_pkt_reg.data))
    else $error("Page register not updated");

  write_seen_c: cover property (@(posedge mclk) disable iff (sys_rst) reg_wr_valid);
  read_byte_c: cover property (@(posedge link_clk) disable iff (rst_link) state_reg == CSP_RD_ACK);
  gen_call_c: cover property (@(posedge link_clk) disable iff (rst_link)
    state_reg == CSP_ADDR_ACK && shift_reg[7:1] == CSP_GC_ADDR);
  master_nack_c: cover property (@(posedge link_clk) disable iff (rst_link)
    state_reg == CSP_RD_ACK && scl_fall && !master_ack_reg);

endmodule : csp_top
`default_nettype wire

// ==== tb/csp_master.sv ====
// Purpose: Behavioural two-wire bus master that stands on the far side of the slave port.
// Assumes: SCL quarter period of 40 mclk cycles, well above five link_clk cycles.
// Notes: SDA is only pulled low or released; the bench adds the pull-up.
`timescale 1ns/1ps
`default_nettype none
module csp_master (
  input wire logic mclk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  // Idle bus: both lines high, nothing pulled.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Quarter of an SCL period.
  task automatic dly;
    repeat (40) @(posedge mclk);
  endtask : dly

  // Sends one bit; data changes only while SCL is low.
  task automatic put(input logic b);
    sda_low <= !b;
    dly();
    scl <= 1'b1;
    dly();
    dly();
    scl <= 1'b0;
    dly();
  endtask : put

  // Releases SDA and samples it in the middle of the high pulse.
  task automatic get(output logic b);
    sda_low <= 1'b0;
    dly();
    scl <= 1'b1;
    dly();
    b = sda_in;
    dly();
    scl <= 1'b0;
    dly();
  endtask : get

  // START or repeated START; SDA falls while SCL is high.
  task automatic start;
    sda_low <= 1'b0;
    dly();
    scl <= 1'b1;
    dly();
    sda_low <= 1'b1;
    dly();
    scl <= 1'b0;
    dly();
  endtask : start

  // STOP; SDA rises while SCL is high, leaving the bus idle.
  task automatic stop;
    sda_low <= 1'b1;
    dly();
    scl <= 1'b1;
    dly();
    sda_low <= 1'b0;
    dly();
  endtask : stop

  // Byte to the slave, MSB first, then the slave's acknowledge.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put(d[i]);
    end
    get(b);
    ack = !b;
  endtask : wbyte

  // Byte from the slave; the master acks to ask for more or leaves SDA high.
  task automatic rbyte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get(d[i]);
    end
    put(!ack);
  endtask : rbyte
endmodule : csp_master
`default_nettype wire

// ==== tb/csp_top_tb.sv ====
// Purpose: Self-checking bench for the two-wire control slave port.
// Assumes: Register-side clock 5 ns, link clock 32 ns with an unrelated phase.
// Notes: Each scenario is a task that judges its own results.
`timescale 1ns/1ps
`default_nettype none
module csp_top_tb;
  import csp_pkg::*;
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  wire logic scl;
  wire logic m_low;
  logic sda_out;
  logic sda_oe_n;
  logic [7:0] cur_page;
  logic gc_enable;
  logic reg_wr_valid;
  csp_wr_t reg_wr;
  csp_wr_t last_wr;
  int error_cnt = 0;
  int compares = 0;
  logic a;
  logic [7:0] d;
  // Open-drain wire with a pull-up: low if either party pulls.
  wire logic sda = !(m_low || !sda_oe_n);
  localparam logic [7:0] WADR = {CSP_DEV_ADDR, 1'b0};

  initial forever #2.5 mclk = ~mclk;
  // Phase offset keeps the two domains unrelated.
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end

  csp_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cur_page(cur_page), .gc_enable(gc_enable),
    .reg_wr_valid(reg_wr_valid), .reg_wr(reg_wr));
  csp_master u_mst (.mclk(mclk), .sda_in(sda), .scl(scl), .sda_low(m_low));

  // Keeps the latest register write event, since the pulse lasts one cycle.
  always @(posedge mclk) if (reg_wr_valid === 1'b1) last_wr <= reg_wr;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Full write: pointer then two data bytes, all acknowledged.
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1);
    u_mst.start();
    u_mst.wbyte(WADR, a);
    chk(a, 1);
    u_mst.wbyte(ptr, a);
    chk(a, 1);
    u_mst.wbyte(d0, a);
    chk(a, 1);
    u_mst.wbyte(d1, a);
    chk(a, 1);
    u_mst.stop();
  endtask : wr

  task automatic t_reset;
    chk(cur_page, 8'h00);
    chk(gc_enable, 0);
    chk(sda_oe_n, 1);
    chk(sda_out, 0);
  endtask : t_reset

  // Foreign address and a disabled general call are both left unanswered.
  task automatic t_foreign;
    u_mst.start();
    u_mst.wbyte(8'h32, a);
    chk(a, 0);
    u_mst.wbyte(8'h22, a);
    chk(a, 0);
    u_mst.stop();
    u_mst.start();
    u_mst.wbyte(8'h00, a);
    chk(a, 0);
    u_mst.stop();
  endtask : t_foreign

  task automatic t_write;
    wr(8'h22, 8'h20, 8'h5A);
    chk(last_wr, {8'h00, 7'h23, 8'h5A});
    chk(gc_enable, 1);
    u_mst.start();
    u_mst.wbyte(8'h00, a);
    chk(a, 1);
    // General call with the read bit must stay unanswered even while enabled.
    u_mst.start();
    u_mst.wbyte(8'h01, a);
    chk(a, 0);
    u_mst.stop();
  endtask : t_write

  // Pointer write, repeated START, two reads ending with a master NACK.
  task automatic t_read;
    u_mst.start();
    u_mst.wbyte(WADR, a);
    u_mst.wbyte(8'h22, a);
    u_mst.start();
    u_mst.wbyte(WADR | 8'h01, a);
    chk(a, 1);
    u_mst.rbyte(1'b1, d);
    chk(d, 8'h20);
    u_mst.rbyte(1'b0, d);
    chk(d, 8'h5A);
    u_mst.stop();
    chk(sda_oe_n, 1);
  endtask : t_read

  task automatic t_page;
    wr(8'h00, 8'h03, 8'h44);
    chk(cur_page, 8'h03);
    chk(last_wr, {8'h03, 7'h01, 8'h44});
    // Register 0 reads back the page that is selected now.
    u_mst.start();
    u_mst.wbyte(WADR, a);
    u_mst.wbyte(8'h00, a);
    u_mst.start();
    u_mst.wbyte(WADR | 8'h01, a);
    u_mst.rbyte(1'b0, d);
    chk(d, 8'h03);
    u_mst.stop();
    wr(8'h00, 8'h00, 8'hC3);
    chk(cur_page, 8'h00);
    chk(last_wr, {8'h00, 7'h01, 8'hC3});
  endtask : t_page

  // STOP cutting a byte short; the next transfer must decode afresh.
  task automatic t_stop_mid;
    u_mst.start();
    u_mst.wbyte(WADR, a);
    u_mst.put(1'b1);
    u_mst.put(1'b0);
    u_mst.stop();
    u_mst.start();
    u_mst.wbyte(WADR, a);
    chk(a, 1);
    u_mst.stop();
  endtask : t_stop_mid

  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (100) @(posedge mclk);
    t_reset();
    t_foreign();
    t_write();
    t_read();
    t_page();
    t_stop_mid();
    give_verdict();
  end

  // Scenarios need about 220 us; a hang is cut off well beyond that.
  initial begin
    #450_000;
    error_cnt++;
    give_verdict();
  end
endmodule : csp_top_tb
`default_nettype wire
